// ==== src/ecbc1_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecbc1_regs
   import ecbc1_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output var ecbc1_ctrl_type ctrl
);
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic hit;
   logic init_r;
   logic init_nxt;
   ecbc1_ctrl_type ctrl_out_r;
   ecbc1_ctrl_type ctrl_out_nxt;
   logic wr_hit;
   logic rd_setup;

   assign hit = (paddr == ECBC1_CTRL_OFFSET);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata = prdata_r;
   assign wr_hit = psel && penable && pwrite && hit;
   assign rd_setup = psel && !penable && !pwrite;

   always_comb begin
      ctrl_nxt = ctrl_r;
      init_nxt = 1'b0;
      prdata_nxt = prdata_r;
      if (psel && !penable && !pwrite) begin
         if (hit) begin
            prdata_nxt = {24'h000000, ctrl_r};
         end else begin
            prdata_nxt = 32'h00000000;
         end
      end
      if (psel && penable && pwrite && hit) begin
         if (pwdata[ECBC1_RESET_BIT]) begin
            // self-clearing: initialization restores defaults, bit 7 included
            ctrl_nxt = ECBC1_CTRL_RESET;
            init_nxt = 1'b1;
         end else begin
            ctrl_nxt = pwdata[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= ECBC1_CTRL_RESET;
         prdata_r <= 32'h00000000;
         init_r <= 1'b1;
      end else begin
         ctrl_r <= ctrl_nxt;
         prdata_r <= prdata_nxt;
         init_r <= init_nxt;
      end
   end

   // decoded from the next register value so the flopped outputs move with ctrl_r
   always_comb begin
      ctrl_out_nxt.noise_injection_disable = ctrl_nxt[ECBC1_INJ_BIT];
      ctrl_out_nxt.back_to_back_select = ctrl_nxt[ECBC1_B2B_BIT];
      ctrl_out_nxt.rx_pad_enable = ctrl_nxt[ECBC1_PAD_BIT];
      ctrl_out_nxt.bypass = ctrl_nxt[ECBC1_BYP_BIT];
      ctrl_out_nxt.adaptation_freeze = ctrl_nxt[ECBC1_ADP_BIT];
      // bypass also halts adaptation
      ctrl_out_nxt.adapt_enable = !ctrl_nxt[ECBC1_ADP_BIT] && !ctrl_nxt[ECBC1_BYP_BIT];
      ctrl_out_nxt.coeff_clear = init_nxt || ctrl_nxt[ECBC1_BYP_BIT];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_out_r <= ECBC1_CTRL_OUT_RESET;
      end else begin
         ctrl_out_r <= ctrl_out_nxt;
      end
   end

   assign ctrl = ctrl_out_r;

   AST_WRITE_STORES: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_hit && !pwdata[ECBC1_RESET_BIT]
      |=>
      ctrl_r == $past(pwdata[7:0])
   ) else $error("write not stored");

   AST_SOFT_RESET: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_hit && pwdata[ECBC1_RESET_BIT]
      |=>
      ctrl_r == ECBC1_CTRL_RESET && ctrl.coeff_clear
   ) else $error("soft reset failed");

   AST_INJ: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1
      |->
      ctrl.noise_injection_disable == ctrl_r[ECBC1_INJ_BIT]
   ) else $error("injection bit mismatch");

   AST_B2B: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1
      |->
      ctrl.back_to_back_select == ctrl_r[ECBC1_B2B_BIT]
   ) else $error("back-to-back mismatch");

   AST_FREEZE: assert property (
      @(posedge pclk) disable iff (!presetn)
      ctrl_r[ECBC1_ADP_BIT]
      |->
      !ctrl.adapt_enable
   ) else $error("adapting while frozen");

   AST_PAD: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1
      |->
      ctrl.rx_pad_enable == ctrl_r[ECBC1_PAD_BIT]
   ) else $error("pad mismatch");

   AST_BYPASS: assert property (
      @(posedge pclk) disable iff (!presetn)
      ctrl.bypass
      |->
      ctrl.coeff_clear && !ctrl.adapt_enable
   ) else $error("bypass bad");

   AST_READ: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_setup && hit
      |=>
      prdata == {24'h000000, $past(ctrl_r)}
   ) else $error("read data wrong");

   AST_INIT_ONLY_ON_RESET: assert property (
      @(posedge pclk) disable iff (!presetn)
      !(wr_hit && pwdata[ECBC1_RESET_BIT])
      |=>
      !init_r
   ) else $error("coefficient clear without reset write");

   AST_RESET_BIT_CLEAR: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1
      |->
      !ctrl_r[ECBC1_RESET_BIT]
   ) else $error("reset bit stored");

   AST_SOFT_RESET_FIELDS: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_hit && pwdata[ECBC1_RESET_BIT]
      |=>
      ctrl.adapt_enable && !ctrl.bypass && !ctrl.rx_pad_enable && !ctrl.back_to_back_select
   ) else $error("fields not defaulted by reset write");

   AST_HOLD_NO_WRITE: assert property (
      @(posedge pclk) disable iff (!presetn)
      !wr_hit
      |=>
      $stable(ctrl_r)
   ) else $error("register changed without write");

   AST_UNMAPPED_WRITE_IGNORED: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite && !hit
      |=>
      $stable(ctrl_r)
   ) else $error("unmapped write changed register");

   AST_READ_NO_SIDE_EFFECT: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && !pwrite
      |=>
      $stable(ctrl_r)
   ) else $error("read changed register");

   AST_UNMAPPED_ERR: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !hit
      |->
      pslverr
   ) else $error("unmapped access without error");

   AST_MAPPED_OK: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && penable && hit
      |->
      !pslverr
   ) else $error("error on mapped access");

   AST_READY: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && penable
      |->
      pready
   ) else $error("access not completed");

   AST_UNMAPPED_READ_ZERO: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_setup && !hit
      |=>
      prdata == 32'h00000000
   ) else $error("unmapped read not zero");

   AST_PRDATA_HOLD: assert property (
      @(posedge pclk) disable iff (!presetn)
      !rd_setup
      |=>
      $stable(prdata)
   ) else $error("read data moved outside setup");

   AST_PRDATA_UPPER_ZERO: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1
      |->
      prdata[31:8] == 24'h000000
   ) else $error("upper read data not zero");

   AST_ADAPT_ON: assert property (
      @(posedge pclk) disable iff (!presetn)
      !ctrl_r[ECBC1_ADP_BIT] && !ctrl_r[ECBC1_BYP_BIT]
      |->
      ctrl.adapt_enable
   ) else $error("not adapting while enabled");

   AST_FREEZE_FLAG: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1
      |->
      ctrl.adaptation_freeze == ctrl_r[ECBC1_ADP_BIT]
   ) else $error("freeze flag mismatch");

   AST_FREEZE_WRITE: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_hit && !pwdata[ECBC1_RESET_BIT] && pwdata[ECBC1_ADP_BIT]
      |=>
      ctrl.adaptation_freeze && !ctrl.adapt_enable
   ) else $error("freeze write not applied");

   AST_NO_BYP_NO_CLEAR: assert property (
      @(posedge pclk) disable iff (!presetn)
      !ctrl_r[ECBC1_BYP_BIT] && !init_r
      |->
      !ctrl.coeff_clear
   ) else $error("coefficients cleared without cause");

   AST_BYPASS_FLAG: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1
      |->
      ctrl.bypass == ctrl_r[ECBC1_BYP_BIT]
   ) else $error("bypass flag mismatch");

   AST_BYPASS_WRITE: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_hit && !pwdata[ECBC1_RESET_BIT] && pwdata[ECBC1_BYP_BIT]
      |=>
      ctrl.bypass && ctrl.coeff_clear && !ctrl.adapt_enable
   ) else $error("bypass write not applied");

   AST_WRITE_FIELDS: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_hit && !pwdata[ECBC1_RESET_BIT]
      |=>
      ctrl.noise_injection_disable == $past(pwdata[ECBC1_INJ_BIT])
      && ctrl.back_to_back_select == $past(pwdata[ECBC1_B2B_BIT])
   ) else $error("field write not applied");

   AST_PAD_WRITE: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_hit && !pwdata[ECBC1_RESET_BIT]
      |=>
      ctrl.rx_pad_enable == $past(pwdata[ECBC1_PAD_BIT])
   ) else $error("pad write not applied");

   COV_WRITE: cover property (
      @(posedge pclk) disable iff (!presetn)
      wr_hit
   );

   COV_SRST: cover property (
      @(posedge pclk) disable iff (!presetn)
      wr_hit && pwdata[ECBC1_RESET_BIT]
   );

   COV_BYP: cover property (
      @(posedge pclk) disable iff (!presetn)
      ctrl.bypass
   );

   COV_FREEZE: cover property (
      @(posedge pclk) disable iff (!presetn)
      ctrl.adaptation_freeze && !ctrl.bypass
   );

   COV_UNMAPPED: cover property (
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !hit
   );
endmodule // ecbc1_regs
`default_nettype wire

// ==== src/ecbc1_pkg.sv ====
// Summary of operation
// - the control register is read/write at offset 0x20 from the group base.
// - writing bit 7 high runs power-up initialization: all bits to default, coefficients zeroed.
// - bit 6 high disables comfort noise injection, low enables it.
// - bit 5 high selects back-to-back configuration, low the normal one.
// - bit 2 high freezes adaptation but keeps cancelling; low adapts continuously.
// - bit 4 high inserts 12 dB receive attenuation; low leaves gains register in control.
// - bit 3 high bypasses both paths, zeroes coefficients and halts adaptation.
package ecbc1_pkg;
   localparam logic [11:0] ECBC1_CTRL_OFFSET = 12'h020;
   localparam logic [7:0] ECBC1_CTRL_RESET = 8'h02;
   localparam int ECBC1_RESET_BIT = 7;
   localparam int ECBC1_INJ_BIT = 6;
   localparam int ECBC1_B2B_BIT = 5;
   localparam int ECBC1_PAD_BIT = 4;
   localparam int ECBC1_BYP_BIT = 3;
   localparam int ECBC1_ADP_BIT = 2;
   localparam logic [4:0] ECBC1_PAD_DB = 5'h0c;
   typedef struct packed {
      logic noise_injection_disable;
      logic back_to_back_select;
      logic rx_pad_enable;
      logic bypass;
      logic adaptation_freeze;
      logic adapt_enable;
      logic coeff_clear;
   } ecbc1_ctrl_type;
   // adaptation enabled, coefficients held clear while in reset
   localparam ecbc1_ctrl_type ECBC1_CTRL_OUT_RESET = 7'h03;
endpackage

// ==== test/echo_canceller_b_control_one_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module echo_canceller_b_control_one_bench;
   import ecbc1_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rs = 32'hb27c;
   logic [7:0] d;
   ecbc1_ctrl_type ctrl;
   logic [32:0] q[$];
   int errors = 0, n_compared = 0;
   always #5 pclk = ~pclk;
   ecbc1_regs i_ecbc1_regs(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ctrl(ctrl));
   task automatic chk(string nm, logic [32:0] e, logic [32:0] s);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   // request held until pready is sampled high
   task automatic apb(logic w, logic [11:0] a, logic [7:0] v);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, v};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rd(logic [11:0] a, logic [32:0] e);
      q.push_back(e);
      apb(0, a, 8'h00);
   endtask
   // the monitor owns the comparison so reads can be queued ahead
   always @(posedge pclk)
      if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0)
         chk("read", q.pop_front(), {pslverr, prdata});
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic stop_test;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      stop_test;
   end
   initial begin
      repeat (10) @(posedge pclk);
      chk("reset ctrl", 33'h03, {26'h0, ctrl});
      presetn <= 1;
      rd(12'h020, {1'b0, 32'h02});
      $display("reset value done");
      for (int i = 0; i < 8; i++) begin
         rs = xs(rs);
         d = {1'b0, rs[6:2], 2'b10};
         apb(1, 12'h020, d);
         repeat (36) @(posedge pclk);
         apb(1, 12'h020, d);
         @(posedge pclk);
         chk("ctrl", {d[6:2], !d[2] && !d[3], d[3]}, ctrl);
         rd(12'h020, {25'h0, d});
      end
      $display("field writes done");
      apb(1, 12'h020, 8'hfe);
      @(negedge pclk);
      chk("coeff_clear", 33'h1, {32'h0, ctrl.coeff_clear});
      @(negedge pclk);
      chk("coeff_clear", 33'h0, {32'h0, ctrl.coeff_clear});
      rd(12'h020, {1'b0, 32'h02});
      apb(1, 12'h024, 8'h5a);
      rd(12'h020, {1'b0, 32'h02});
      rd(12'h024, {1'b1, 32'h0});
      @(posedge pclk);
      $display("soft reset and unmapped done");
      stop_test;
   end
endmodule // echo_canceller_b_control_one_bench
`default_nettype wire
